// [rtl/cpurf_core.sv]
/*
 * CPU core register file: accumulator, index pair, stack pointer,
 * program counter, reset vector fetch, flag register and mul/div.
 * Assumes memory returns read data one cycle after the address.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cpurf_consts.svh"
module cpurf_core
  import cpurf_pkg::*;
(
  input  wire logic        core_clk_i,    // Core clock, 250 MHz.
  input  wire logic        reset_i,       // Synchronous reset, high.
  input  wire logic [7:0]  mem_rdata_i,   // Memory read data.
  input  wire logic        acc_we_i,      // Load accumulator.
  input  wire logic [7:0]  acc_d_i,       // Accumulator value (ALU result).
  input  wire logic        idx_hi_we_i,   // Load upper index byte.
  input  wire logic [7:0]  idx_hi_d_i,    // Upper index value.
  input  wire cpurf_xop_t  xop_i,         // Lower index byte operation.
  input  wire logic [7:0]  idx_lo_d_i,    // Lower index load value.
  input  wire cpurf_sop_t  sop_i,         // Stack pointer operation.
  input  wire logic [7:0]  imm_i,         // Immediate or displacement.
  input  wire logic [15:0] sp_d_i,        // Stack pointer load value.
  input  wire logic        pc_inc_i,      // Fetch done, advance.
  input  wire logic        pc_ld_i,       // Change of flow.
  input  wire logic [15:0] pc_d_i,        // Change of flow target.
  input  wire logic        pc_rel_i,      // Relative branch taken.
  input  wire logic        int_stk_done_i,// Interrupt stacking finished.
  input  wire logic        flag_we_i,     // Update result flags.
  input  wire logic [7:0]  flag_i,        // Result flags.
  input  wire logic        flag_ld_i,     // Load flag register.
  input  wire logic [7:0]  direct_i,      // Direct page address byte.
  input  wire logic [7:0]  divisor_i,     // Divisor.
  output logic      [15:0] mem_addr_o,    // Memory address.
  output logic             mem_rd_o,      // Memory read strobe.
  output logic             running_o,     // Vector fetched, executing.
  output logic      [7:0]  acc_o,         // Accumulator.
  output logic      [15:0] idx_o,         // Full index pointer.
  output logic      [15:0] sp_o,          // Stack pointer.
  output logic      [15:0] pc_o,          // Program counter.
  output logic      [15:0] direct_addr_o, // Direct page address.
  output logic      [7:0]  flags_o,       // Flag register.
  output logic      [15:0] prod_o,        // Product.
  output logic      [15:0] quot_o,        // Quotient.
  output logic      [7:0]  rem_o          // Remainder.
);
  //////////////////////////////////////////////////////////////////////
  // Registers and next values.
  logic [7:0]   acc_q, acc_d;
  logic [7:0]   idx_hi_q, idx_hi_d;
  logic [7:0]   idx_lo_q, idx_lo_d;
  logic [15:0]  sp_q, sp_d;
  logic [15:0]  pc_q, pc_d;
  logic [7:0]   vec_hi_q;
  cpurf_state_t st_q, st_d;
  logic [15:0]  addr_q, addr_d;
  logic         rd_q, rd_d;
  logic [15:0]  dir_q;
  logic [7:0]   flags_w;
  logic         carry_w;
  logic         run_w;
  logic         run_q;

  // Sign extension shared by stack adjust and relative branch.
  function automatic logic [15:0] cpurf_sext(input logic [7:0] b);
    cpurf_sext = {{8{b[7]}}, b};
  endfunction : cpurf_sext

  assign run_w   = (st_q == CPURF_ST_RUN);
  assign carry_w = flags_w[`CPURF_FLAG_C];

  //////////////////////////////////////////////////////////////////////
  // Accumulator: reset never touches it; it feeds the ALU via acc_o.
  assign acc_d = (run_w && acc_we_i) ? acc_d_i : acc_q;
  // Upper index byte, untouched by the legacy lower-byte operations.
  assign idx_hi_d = (run_w && idx_hi_we_i) ? idx_hi_d_i
                                            : idx_hi_q;

  // Lower index byte as a general data register.
  always_comb begin
    idx_lo_d = idx_lo_q;
    if (run_w) begin
      case (xop_i)
        CPURF_XOP_CLR: idx_lo_d = 8'h00;
        CPURF_XOP_INC: idx_lo_d = idx_lo_q + 8'h01;
        CPURF_XOP_DEC: idx_lo_d = idx_lo_q - 8'h01;
        CPURF_XOP_COM: idx_lo_d = ~idx_lo_q;
        CPURF_XOP_NEG: idx_lo_d = 8'h00 - idx_lo_q;
        CPURF_XOP_LSL: idx_lo_d = {idx_lo_q[6:0], 1'b0};
        CPURF_XOP_LSR: idx_lo_d = {1'b0, idx_lo_q[7:1]};
        CPURF_XOP_ROL: idx_lo_d = {idx_lo_q[6:0], carry_w};
        CPURF_XOP_ROR: idx_lo_d = {carry_w, idx_lo_q[7:1]};
        CPURF_XOP_TAX: idx_lo_d = acc_q;
        CPURF_XOP_LD:  idx_lo_d = idx_lo_d_i;
        default:       idx_lo_d = idx_lo_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Stack pointer: push moves it down, it always names the free slot.
  always_comb begin
    sp_d = sp_q;
    if (run_w) begin
      case (sop_i)
        CPURF_SOP_AIS:  sp_d = sp_q + cpurf_sext(imm_i);
        CPURF_SOP_RSP:  sp_d = {sp_q[15:8], `CPURF_RSP_LOW};
        CPURF_SOP_PUSH: sp_d = sp_q - 16'h0001;
        CPURF_SOP_PULL: sp_d = sp_q + 16'h0001;
        CPURF_SOP_LD:   sp_d = sp_d_i;
        default:        sp_d = sp_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Reset vector fetch: high byte, then low byte, then execution.
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    rd_d   = 1'b0;
    case (st_q)
      CPURF_ST_VEC_HI: begin
        st_d   = CPURF_ST_VEC_LO;
        addr_d = `CPURF_VEC_LO_ADDR;
        rd_d   = 1'b1;
      end
      CPURF_ST_VEC_LO: begin
        st_d   = CPURF_ST_RUN;
        addr_d = pc_d;
        rd_d   = 1'b1;
      end
      CPURF_ST_RUN: begin
        addr_d = pc_d;
        rd_d   = 1'b1;
      end
      default: st_d = CPURF_ST_VEC_HI;
    endcase
  end

  // Program counter: sequential advance or change of flow.
  always_comb begin
    pc_d = pc_q;
    if (st_q == CPURF_ST_VEC_LO) begin
      pc_d = {vec_hi_q, mem_rdata_i};
    end else if (run_w) begin
      if (pc_ld_i) begin
        pc_d = pc_d_i;
      end else if (pc_rel_i) begin
        pc_d = pc_q + cpurf_sext(imm_i);
      end else if (pc_inc_i) begin
        pc_d = pc_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State registers; the accumulator and lower index skip reset.
  always_ff @(posedge core_clk_i) begin
    acc_q    <= acc_d;
    idx_lo_q <= idx_lo_d;
    dir_q    <= {`CPURF_DIRECT_HI, direct_i};
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx_hi_q <= 8'h00;
      sp_q     <= `CPURF_SP_RESET;
      pc_q     <= 16'h0000;
      vec_hi_q <= 8'h00;
      st_q     <= CPURF_ST_VEC_HI;
      addr_q   <= `CPURF_VEC_HI_ADDR;
      rd_q     <= 1'b1;
      run_q    <= 1'b0;
    end else begin
      run_q    <= (st_d == CPURF_ST_RUN);
      idx_hi_q <= idx_hi_d;
      sp_q     <= sp_d;
      pc_q     <= pc_d;
      vec_hi_q <= (st_q == CPURF_ST_VEC_HI) ? mem_rdata_i : vec_hi_q;
      st_q     <= st_d;
      addr_q   <= addr_d;
      rd_q     <= rd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Flag register and mul/div unit.
  cpurf_flags u_flags (
    .clk_i       (core_clk_i),
    .reset_i     (reset_i),
    .flag_we_i   (run_w & flag_we_i),
    .flag_i      (flag_i),
    .flag_ld_i   (run_w & flag_ld_i),
    .flag_ld_d_i (acc_q),
    .mask_set_i  (run_w & int_stk_done_i),
    .flags_o     (flags_w)
  );

  cpurf_muldiv u_muldiv (
    .clk_i      (core_clk_i),
    .mul_a_i    (acc_q),
    .mul_b_i    (idx_lo_q),
    .dividend_i ({idx_hi_q, acc_q}),
    .divisor_i  (divisor_i),
    .prod_o     (prod_o),
    .quot_o     (quot_o),
    .rem_o      (rem_o),
    .dzero_o    ()
  );

  //////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops.
  assign mem_addr_o    = addr_q;
  assign mem_rd_o      = rd_q;
  assign running_o     = run_q;
  assign acc_o         = acc_q;
  assign idx_o         = {idx_hi_q, idx_lo_q};
  assign sp_o          = sp_q;
  assign pc_o          = pc_q;
  assign direct_addr_o = dir_q;
  assign flags_o       = flags_w;

  //////////////////////////////////////////////////////////////////////
  // Checks.
  chk_idx_hi_reset: assert property (@(posedge core_clk_i)
    reset_i |=> (idx_hi_q == 8'h00))
    else $error("upper index byte not cleared by reset");
  // Checked on a reset that arrives in mid-run: at power-up both
  // registers hold no value yet, so there is nothing to keep.
  chk_idx_lo_keep: assert property (@(posedge core_clk_i)
    (reset_i && run_w) |=> (idx_lo_q == $past(idx_lo_q)))
    else $error("lower index byte changed by reset");
  chk_acc_keep: assert property (@(posedge core_clk_i)
    (reset_i && run_w) |=> (acc_q == $past(acc_q)))
    else $error("accumulator changed by reset");
  chk_sp_reset: assert property (@(posedge core_clk_i)
    reset_i |=> (sp_q == 16'h00FF))
    else $error("stack pointer reset value wrong");
  chk_sp_ais_add: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (run_w && sop_i == CPURF_SOP_AIS) |=>
    (sp_q == $past(sp_q) + {{8{$past(imm_i[7])}}, $past(imm_i)}))
    else $error("stack adjust wrong");
  chk_rsp_high_keep: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (run_w && sop_i == CPURF_SOP_RSP) |=>
    (sp_q[15:8] == $past(sp_q[15:8])) && (sp_q[7:0] == 8'hFF))
    else $error("reset-stack changed upper byte");
  chk_pc_inc_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (run_w && pc_inc_i && !pc_ld_i && !pc_rel_i) |=>
    (pc_q == $past(pc_q) + 16'h0001))
    else $error("program counter did not advance");
  chk_pc_flow_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (run_w && pc_ld_i) |=> (pc_q == $past(pc_d_i)))
    else $error("change of flow not loaded");
  chk_vec_fetch: assert property (@(posedge core_clk_i)
    $fell(reset_i) |-> (mem_addr_o == 16'hFFFE) ##1
    (mem_addr_o == 16'hFFFF) ##1 running_o [*1] ##0
    (pc_q == {$past(mem_rdata_i, 2), $past(mem_rdata_i)}))
    else $error("reset vector fetch wrong");
  chk_idx_hi_legacy: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (run_w && !idx_hi_we_i && xop_i != CPURF_XOP_NONE) |=>
    (idx_hi_q == $past(idx_hi_q)))
    else $error("lower byte op changed upper byte");
  chk_mask_after_stk: assert property (@(posedge core_clk_i)
    disable iff (reset_i)
    (run_w && int_stk_done_i) |=> flags_w[3])
    else $error("interrupt mask not set after stacking");
  cov_vec_done: cover property (@(posedge core_clk_i)
    $fell(reset_i) ##2 running_o);
  cov_ais_neg: cover property (@(posedge core_clk_i)
    run_w && sop_i == CPURF_SOP_AIS && imm_i[7]);
  cov_rel_branch: cover property (@(posedge core_clk_i)
    run_w && pc_rel_i);
endmodule : cpurf_core
`default_nettype wire

// [rtl/cpurf_consts.svh]
/*
 * Constants for the CPU core register file: reset values, vector
 * addresses and flag bit positions.
 * Assumes it is included by bare name from files under rtl/.
 */
// Operation
// - Eight-bit accumulator drives one ALU operand; reset leaves it unchanged.
// - Index pointer is upper and lower byte joined into sixteen bits.
// - Reset clears the upper index byte and keeps the lower byte.
// - Legacy operations touch only the lower index byte.
// - Lower index byte acts as data register with unary ops and transfers.
// - Sixteen-bit stack pointer addresses the next free stack location.
// - Reset loads the stack pointer with the top of the direct page.
// - Add-immediate adds a sign-extended byte to the stack pointer.
// - Reset-stack operation changes only the stack pointer low byte.
// - Program counter advances by one after each fetch.
// - Jump, branch, interrupt and return load a new program counter.
// - Reset fetches the program counter from the two topmost bytes.
// - One 64-Kbyte address space; CPU registers are not mapped.
// - Direct addressing reaches only the first 256-byte page.
// - Relative addressing adds a signed byte displacement.
// - Calls push the return address; interrupts push registers too.
// - Datapath multiplies eight by eight and divides sixteen by eight.
// - Overflow, half-carry, negative, zero and carry flags are kept.
// - Flag register holds mask and five flags; bits six, five read one.
// - Interrupt mask sets after stacking, before the first handler op.
`ifndef CPURF_CONSTS_SVH
`define CPURF_CONSTS_SVH
`define CPURF_SP_RESET     16'h00FF
`define CPURF_RSP_LOW      8'hFF
`define CPURF_VEC_HI_ADDR  16'hFFFE
`define CPURF_VEC_LO_ADDR  16'hFFFF
`define CPURF_DIRECT_HI    8'h00
`define CPURF_FLAG_V       7
`define CPURF_FLAG_ONE6    6
`define CPURF_FLAG_ONE5    5
`define CPURF_FLAG_H       4
`define CPURF_FLAG_I       3
`define CPURF_FLAG_N       2
`define CPURF_FLAG_Z       1
`define CPURF_FLAG_C       0
`define CPURF_FLAG_FIXED   8'h60
`endif

// [rtl/cpurf_pkg.sv]
/*
 * Types for the CPU core register file: operation selectors.
 * Assumes the constants header is available for the users.
 */
package cpurf_pkg;
  // Operation applied to the lower index byte.
  typedef enum logic [3:0] {
    CPURF_XOP_NONE = 4'h0,
    CPURF_XOP_CLR  = 4'h1,
    CPURF_XOP_INC  = 4'h2,
    CPURF_XOP_DEC  = 4'h3,
    CPURF_XOP_COM  = 4'h4,
    CPURF_XOP_NEG  = 4'h5,
    CPURF_XOP_LSL  = 4'h6,
    CPURF_XOP_LSR  = 4'h7,
    CPURF_XOP_ROL  = 4'h8,
    CPURF_XOP_ROR  = 4'h9,
    CPURF_XOP_TAX  = 4'hA,
    CPURF_XOP_LD   = 4'hB
  } cpurf_xop_t;
  // Operation applied to the stack pointer.
  typedef enum logic [2:0] {
    CPURF_SOP_NONE = 3'h0,
    CPURF_SOP_AIS  = 3'h1,
    CPURF_SOP_RSP  = 3'h2,
    CPURF_SOP_PUSH = 3'h3,
    CPURF_SOP_PULL = 3'h4,
    CPURF_SOP_LD   = 3'h5
  } cpurf_sop_t;
  // Reset vector fetch state.
  typedef enum logic [1:0] {
    CPURF_ST_VEC_HI = 2'b00,
    CPURF_ST_VEC_LO = 2'b01,
    CPURF_ST_RUN    = 2'b10
  } cpurf_state_t;
endpackage : cpurf_pkg

// [rtl/cpurf_muldiv.sv]
/*
 * Multiply and divide unit: 8x8 product, 16/8 quotient and remainder.
 * Assumes the caller holds operands steady; results are registered.
 */
`timescale 1ns/100ps
`default_nettype none
module cpurf_muldiv
  import cpurf_pkg::*;
(
  input  wire logic        clk_i,     // Core clock.
  input  wire logic [7:0]  mul_a_i,   // Multiplicand.
  input  wire logic [7:0]  mul_b_i,   // Multiplier.
  input  wire logic [15:0] dividend_i,// Dividend.
  input  wire logic [7:0]  divisor_i, // Divisor.
  output logic      [15:0] prod_o,    // Registered product.
  output logic      [15:0] quot_o,    // Registered quotient.
  output logic      [7:0]  rem_o,     // Registered remainder.
  output logic             dzero_o    // Divisor was zero.
);
  logic [15:0] prod_d;
  logic [15:0] quot_d;
  logic [7:0]  rem_d;
  logic        dz_d;
  // Combinational arithmetic; zero divisor yields an all-ones quotient and a zero remainder, no trap.
  assign prod_d = 16'(mul_a_i) * 16'(mul_b_i);
  assign dz_d   = (divisor_i == 8'h00);
  assign quot_d = dz_d ? 16'hFFFF : dividend_i / {8'h00, divisor_i};
  assign rem_d  = dz_d ? 8'h00 :
                  8'((dividend_i % {8'h00, divisor_i}) & 16'h00FF);
  // One register stage keeps the divider off the core's critical path.
  always_ff @(posedge clk_i) begin
    prod_o  <= prod_d;
    quot_o  <= quot_d;
    rem_o   <= rem_d;
    dzero_o <= dz_d;
  end
endmodule : cpurf_muldiv
`default_nettype wire

// [rtl/cpurf_flags.sv]
/*
 * Condition flag register: interrupt mask plus five result flags.
 * Assumes the core supplies flag update strobes one cycle at a time.
 */
`timescale 1ns/100ps
`default_nettype none
`include "cpurf_consts.svh"
module cpurf_flags
  import cpurf_pkg::*;
(
  input  wire logic       clk_i,      // Core clock.
  input  wire logic       reset_i,    // Synchronous reset, high.
  input  wire logic       flag_we_i,  // Write result flags.
  input  wire logic [7:0] flag_i,     // New result flag values.
  input  wire logic       flag_ld_i,  // Load whole register.
  input  wire logic [7:0] flag_ld_d_i,// Value for full load.
  input  wire logic       mask_set_i, // Set interrupt mask.
  output logic      [7:0] flags_o     // Flag register value.
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  localparam logic [7:0] RES_MASK = 8'h97;
  // Load, result update, then mask set; bits six and five forced high.
  always_comb begin
    flags_d = flags_q;
    if (flag_ld_i) begin
      flags_d = flag_ld_d_i;
    end else if (flag_we_i) begin
      flags_d = (flags_q & ~RES_MASK) | (flag_i & RES_MASK);
    end
    if (mask_set_i) begin
      flags_d[`CPURF_FLAG_I] = 1'b1;
    end
    flags_d = flags_d | `CPURF_FLAG_FIXED;
  end
  // Reset masks interrupts so nothing fires before setup.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_q <= `CPURF_FLAG_FIXED | 8'h08;
    end else begin
      flags_q <= flags_d;
    end
  end
  assign flags_o = flags_q;
  chk_flags_fixed_ones: assert property (@(posedge clk_i)
    disable iff (reset_i) (flags_q[6:5] == 2'b11))
    else $error("flag bits six and five not one");
endmodule : cpurf_flags
`default_nettype wire

// [tb/cpurf_mem_model.sv]
/*
 * Memory model for the shared address space, vector word at the top.
 * Assumes the core reads one byte per edge, data one edge later.
 */
`timescale 1ns/100ps
`default_nettype none
module cpurf_mem_model #(
  parameter logic [15:0] VEC = 16'h4C21  // Vector word, arbitrary.
) (
  input  wire logic        clk_i,   // Core clock.
  input  wire logic [15:0] addr_i,  // Read address.
  input  wire logic        rd_i,    // Read strobe.
  output var  logic [7:0]  rdata_o  // Read data.
);
  logic [7:0] byte_w;
  // Top two bytes hold the vector; every other byte mixes its address.
  assign byte_w = (addr_i == 16'hFFFE) ? VEC[15:8] :
                  (addr_i == 16'hFFFF) ? VEC[7:0] :
                  addr_i[15:8] ^ addr_i[7:0];
  // Launched on the falling edge, so the byte for an address put out
  // at one rising edge is settled by the next rising edge.
  // Idle reads toggle, so stale data never looks like a good byte.
  always_ff @(negedge clk_i) begin
    rdata_o <= rd_i ? byte_w : ~rdata_o;
  end
endmodule : cpurf_mem_model
`default_nettype wire

// [tb/cpu_core_register_file_bench.sv]
/*
 * Self-checking bench for the core register file: a driver keeps a
 * reference copy of every register and queues it, a monitor compares.
 * Assumes the memory model answers the vector fetch after reset.
 */
`timescale 1ns/100ps
`default_nettype none
module cpu_core_register_file_bench
  import cpurf_pkg::*;
;
  localparam logic [15:0] VEC = 16'h4C21;  // Arbitrary vector word.
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0]  fl;
    logic [15:0] da;
    logic        dv;
    logic        md;
    logic [15:0] prod;
    logic [15:0] quot;
    logic [7:0]  rem;
  } cpurf_note_t;
  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic        acc_we_i, idx_hi_we_i, pc_inc_i, pc_ld_i, pc_rel_i;
  logic        int_stk_done_i, flag_we_i, flag_ld_i, mem_rd_o, running_o;
  logic [7:0]  mem_rdata_i, acc_d_i, idx_hi_d_i, idx_lo_d_i, imm_i;
  logic [7:0]  flag_i, direct_i, divisor_i, acc_o, flags_o, rem_o;
  logic [15:0] sp_d_i, pc_d_i, mem_addr_o, idx_o, sp_o, pc_o;
  logic [15:0] direct_addr_o, prod_o, quot_o, dvd;
  cpurf_xop_t  xop_i;
  cpurf_sop_t  sop_i;
  cpurf_note_t m, n;
  cpurf_note_t notes [$];
  int          fails = 0;
  int          n_compared = 0;
  logic [31:0] seed, r;
  cpurf_sop_t  sops [6] = '{CPURF_SOP_AIS, CPURF_SOP_AIS, CPURF_SOP_AIS,
                            CPURF_SOP_RSP, CPURF_SOP_PUSH, CPURF_SOP_PULL};
  logic [7:0]  imms [6] = '{8'h80, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00};

  always #2 core_clk_i = ~core_clk_i;

  cpurf_mem_model #(.VEC(VEC)) mem (.clk_i(core_clk_i), .addr_i(mem_addr_o),
    .rd_i(mem_rd_o), .rdata_o(mem_rdata_i));
  cpurf_core uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .mem_rdata_i(mem_rdata_i), .acc_we_i(acc_we_i), .acc_d_i(acc_d_i),
    .idx_hi_we_i(idx_hi_we_i), .idx_hi_d_i(idx_hi_d_i), .xop_i(xop_i),
    .idx_lo_d_i(idx_lo_d_i), .sop_i(sop_i), .imm_i(imm_i), .sp_d_i(sp_d_i),
    .pc_inc_i(pc_inc_i), .pc_ld_i(pc_ld_i), .pc_d_i(pc_d_i),
    .pc_rel_i(pc_rel_i), .int_stk_done_i(int_stk_done_i),
    .flag_we_i(flag_we_i), .flag_i(flag_i), .flag_ld_i(flag_ld_i),
    .direct_i(direct_i), .divisor_i(divisor_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .running_o(running_o), .acc_o(acc_o),
    .idx_o(idx_o), .sp_o(sp_o), .pc_o(pc_o), .direct_addr_o(direct_addr_o),
    .flags_o(flags_o), .prod_o(prod_o), .quot_o(quot_o), .rem_o(rem_o));

  ////////////////////////////////////////////////////////////////////////
  task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp8

  task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: exp %h got %h", $time, e, g);
    end
  endtask : cmp16

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  // Reset, strobes idle; the vector must land two edges after release.
  task automatic do_reset;
    int k;
    @(negedge core_clk_i);
    reset_i = 1'b1;
    {acc_we_i, idx_hi_we_i, pc_inc_i, pc_ld_i, pc_rel_i} = '0;
    {int_stk_done_i, flag_we_i, flag_ld_i} = '0;
    xop_i = CPURF_XOP_NONE;
    sop_i = CPURF_SOP_NONE;
    repeat (3) @(negedge core_clk_i);
    reset_i = 1'b0;
    k = 0;
    while (running_o !== 1'b1 && k < 10) begin
      @(posedge core_clk_i);
      #1 k++;
    end
    cmp8(8'(k), 8'h02);
    {m.hi, m.sp, m.pc, m.fl, m.dv, m.md} = {8'h00, 16'h00FF, VEC, 8'h68, 2'b00};
    notes.push_back(m);
  endtask : do_reset

  // Strobe bits: acc, hi, inc, ld, rel, stacked, flag write, flag load.
  task automatic step(input logic [7:0] st, input cpurf_xop_t x,
      input cpurf_sop_t s, input logic [15:0] a, b, c, input logic md);
    @(negedge core_clk_i);
    {acc_we_i, idx_hi_we_i, pc_inc_i, pc_ld_i, pc_rel_i} = st[7:3];
    {int_stk_done_i, flag_we_i, flag_ld_i} = st[2:0];
    xop_i = x;
    sop_i = s;
    {idx_hi_d_i, acc_d_i} = a;
    flag_i = a[15:8];
    {imm_i, idx_lo_d_i} = b;
    {divisor_i, direct_i} = b;
    sp_d_i = c;
    pc_d_i = ~c;
    case (x)
      CPURF_XOP_CLR: m.lo = 8'h00;
      CPURF_XOP_INC: m.lo = m.lo + 8'h01;
      CPURF_XOP_DEC: m.lo = m.lo - 8'h01;
      CPURF_XOP_COM: m.lo = ~m.lo;
      CPURF_XOP_NEG: m.lo = 8'h00 - m.lo;
      CPURF_XOP_LSL: m.lo = {m.lo[6:0], 1'b0};
      CPURF_XOP_LSR: m.lo = {1'b0, m.lo[7:1]};
      CPURF_XOP_ROL: m.lo = {m.lo[6:0], m.fl[0]};
      CPURF_XOP_ROR: m.lo = {m.fl[0], m.lo[7:1]};
      CPURF_XOP_TAX: m.lo = m.acc;
      CPURF_XOP_LD:  m.lo = idx_lo_d_i;
      default:       m.lo = m.lo;
    endcase
    case (s)
      CPURF_SOP_AIS:  m.sp = m.sp + {{8{imm_i[7]}}, imm_i};
      CPURF_SOP_RSP:  m.sp = {m.sp[15:8], 8'hFF};
      CPURF_SOP_PUSH: m.sp = m.sp - 16'h0001;
      CPURF_SOP_PULL: m.sp = m.sp + 16'h0001;
      CPURF_SOP_LD:   m.sp = sp_d_i;
      default:        m.sp = m.sp;
    endcase
    if (pc_ld_i) m.pc = pc_d_i;
    else if (pc_rel_i) m.pc = m.pc + {{8{imm_i[7]}}, imm_i};
    else if (pc_inc_i) m.pc = m.pc + 16'h0001;
    if (flag_ld_i) m.fl = m.acc | 8'h60;
    if (flag_we_i) m.fl = (flag_i & 8'h97) | (m.fl & 8'h68);
    if (int_stk_done_i) m.fl = m.fl | 8'h08;
    if (acc_we_i) m.acc = acc_d_i;
    if (idx_hi_we_i) m.hi = idx_hi_d_i;
    {m.da, m.dv, m.md} = {8'h00, direct_i, 1'b1, md};
    dvd = {m.hi, m.acc};
    m.prod = 16'(m.acc) * 16'(m.lo);
    m.quot = (divisor_i == 8'h00) ? 16'hFFFF : dvd / 16'(divisor_i);
    m.rem = (divisor_i == 8'h00) ? 8'h00 : 8'(dvd % 16'(divisor_i));
    @(posedge core_clk_i);
    #1 notes.push_back(m);
  endtask : step

  ////////////////////////////////////////////////////////////////////////
  // Monitor: each registered result is checked against the oldest note.
  always @(negedge core_clk_i) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      cmp8(n.acc, acc_o);
      cmp16({n.hi, n.lo}, idx_o);
      cmp16(n.sp, sp_o);
      cmp16(n.pc, pc_o);
      cmp16(n.pc, mem_addr_o);
      cmp8(8'h01, {7'h00, mem_rd_o});
      cmp8(n.fl, flags_o);
      if (n.dv) cmp16(n.da, direct_addr_o);
      if (n.md) cmp16(n.prod, prod_o);
      if (n.md) cmp16(n.quot, quot_o);
      if (n.md) cmp8(n.rem, rem_o);
    end
  end

  // Watchdog: the tests take well under a thousand cycles.
  initial begin
    #40000 fails++;
    test_done();
  end

  // Main sequence.
  initial begin
    seed = 32'h5c6d5970;
    {acc_d_i, idx_hi_d_i, idx_lo_d_i, imm_i, flag_i} = '0;
    {direct_i, divisor_i, sp_d_i, pc_d_i} = '0;
    {acc_we_i, idx_hi_we_i, pc_inc_i, pc_ld_i, pc_rel_i} = '0;
    {int_stk_done_i, flag_we_i, flag_ld_i} = '0;
    xop_i = CPURF_XOP_NONE;
    sop_i = CPURF_SOP_NONE;
    do_reset();
    for (int k = 1; k < 12; k++) begin
      r = $random(seed);
      step(8'hC2, CPURF_XOP_LD, CPURF_SOP_NONE, r[15:0], r[31:16], 16'h0, 0);
      step(8'h00, cpurf_xop_t'(k), CPURF_SOP_NONE, r[31:16], r[15:0], 0, 0);
    end
    $display("test index ops done");
    r = $random(seed);
    step(8'h00, CPURF_XOP_NONE, CPURF_SOP_LD, 0, 0, r[15:0] | 16'h8000, 0);
    for (int k = 0; k < 6; k++) begin
      r = $random(seed);
      step(8'h00, CPURF_XOP_NONE, sops[k], 0, {imms[k], r[7:0]}, 0, 0);
    end
    $display("test stack ops done");
    r = $random(seed);
    step(8'h20, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 0, 0, 0);
    step(8'h10, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 0, r[15:0], 0);
    step(8'h08, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 16'h8000, 0, 0);
    step(8'h28, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 16'h7F00, 0, 0);
    step(8'h38, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 16'h0100, r[31:16], 0);
    $display("test program counter done");
    step(8'h02, CPURF_XOP_NONE, CPURF_SOP_NONE, 16'hFF00, 0, 0, 0);
    step(8'h02, CPURF_XOP_NONE, CPURF_SOP_NONE, 16'h0000, 0, 0, 0);
    step(8'h04, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 0, 0, 0);
    step(8'h80, CPURF_XOP_NONE, CPURF_SOP_NONE, 16'h0000, 0, 0, 0);
    step(8'h01, CPURF_XOP_NONE, CPURF_SOP_NONE, 16'h00FF, 0, 0, 0);
    step(8'h81, CPURF_XOP_NONE, CPURF_SOP_NONE, 16'h00FF, 0, 0, 0);
    step(8'h04, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 0, 0, 0);
    $display("test flags done");
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      if (k == 3) r[31:24] = 8'h00;
      step(8'hC0, CPURF_XOP_LD, CPURF_SOP_NONE, r[15:0], r[31:16], 0, 0);
      step(8'h00, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, r[31:16], 0, 1);
    end
    $display("test multiply divide done");
    do_reset();
    step(8'h00, CPURF_XOP_NONE, CPURF_SOP_NONE, 0, 0, 0, 0);
    $display("test second reset done");
    repeat (2) @(negedge core_clk_i);
    test_done();
  end
endmodule : cpu_core_register_file_bench
`default_nettype wire
